// [keypad_consts.vh]
/*
 * Constants of the keypad scan and report block: register offsets on the
 * APB bus, field positions, reset values and timing figures.
 * Assumes it is included by bare name from the design file.
 */
`ifndef KEYPAD_CONSTS_VH
`define KEYPAD_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_COLUMN_ENABLE 12'h000
`define OFS_CTRL_HIGH 12'h004
`define OFS_CTRL_LOW 12'h008
`define OFS_ROW_ENABLE_LOW 12'h00c
`define OFS_ROW_ENABLE_HIGH 12'h010
`define OFS_SYS_CTRL 12'h014
`define OFS_KEY_RECORD_0 12'h018
`define OFS_KEY_RECORD_1 12'h01c
`define OFS_KEY_RECORD_2 12'h020
`define OFS_SPECIAL_STATUS 12'h024
`define OFS_DEDICATED_STATUS 12'h028

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_LOW_SCAN_BIT 0
`define CTRL_LOW_DEBOUNCE_LSB 1
`define CTRL_HIGH_CONFIRM_LSB 4
`define SYS_CLOCK_ENABLE_BIT 0
`define RECORD_RELEASE_BIT 7
`define RECORD_ROW_LSB 3

// ****************************************************************
// Reset values
// ****************************************************************
`define KEY_RECORD_RESET 8'hf8
`define SPECIAL_STATUS_RESET 8'hff
`define DEDICATED_STATUS_RESET 8'h0f
`define NO_KEY_ROW 4'hf

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_PERIOD_NS 5
`define ROW_DWELL_NS 1000
`define ROW_DWELL_CYCLES (`ROW_DWELL_NS / `CLOCK_PERIOD_NS)
`define DEBOUNCE_STEP_NS 1000000
`define DEBOUNCE_STEP_CYCLES (`DEBOUNCE_STEP_NS / `CLOCK_PERIOD_NS)

`endif

// [keypad_scan_report.v]
/*
 * Keypad matrix scanner with key reporting and an APB register slave.
 * Assumes a 12-row by 8-column switch matrix, rows driven active low, columns
 * pulled up in the pad and read through pins outside the clock domain.
 * Matrix and special keys pass confirmation together; dedicated keys skip it,
 * so they answer within a few clocks but carry no debounce.
 */
`include "keypad_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module keypad_scan_report #(
   parameter ROWS = 12,
   parameter COLS = 8,
   parameter DWELL_CYCLES = `ROW_DWELL_CYCLES,
   parameter DEBOUNCE_STEP = `DEBOUNCE_STEP_CYCLES
)
(
   // Clock and reset
   input wire clock,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Keypad pins
   output reg [ROWS-1:0] row_out,
   output reg [ROWS-1:0] row_oe,
   input wire [COLS-1:0] column_in,
   output wire [COLS-1:0] column_pullup,
   // Interrupt level
   output reg key_irq
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Control bytes hold what the host wrote; unused row bits read zero
   reg [7:0] column_enable_r; // Columns in use as keypad inputs
   reg [7:0] keypad_ctrl_high_r; // Confirm count and dedicated selects
   reg [7:0] keypad_ctrl_low_r; // Debounce and scan
   reg [7:0] row_enable_low_r; // Rows 0..7
   reg [7:0] row_enable_high_r; // Rows 8..11
   reg keypad_clock_enable_r; // Gates the controller
   reg [7:0] rec_r [0:2]; // Reported matrix key records
   reg [7:0] special_key_status_r; // Special function key byte
   reg [3:0] dedicated_key_status_r; // Dedicated key nibble
   reg unread_r; // Buffered events not yet read

   // Synchronised columns, first stage read only by second
   reg [COLS-1:0] col_meta_r;
   reg [COLS-1:0] col_sync_r;

   // Scan state
   // Maps hold row r in bits r*8+7 down to r*8
   reg [3:0] row_idx_r; // Row being driven
   reg [15:0] dwell_r; // Settle counter on a row
   reg [95:0] frame_r; // Pressed map built during a frame
   reg [95:0] stable_r; // Last debounced map
   reg [7:0] special_acc_r; // Special keys seen in frame
   reg [31:0] deb_cnt_r; // Debounce timer
   reg [3:0] confirm_r; // Frames the map has stayed the same
   reg [95:0] cand_r; // Candidate map under confirmation
   reg [7:0] special_cand_r; // Candidate special keys
   reg [7:0] special_stable_r; // Confirmed special keys, as reported
   reg [3:0] ded_prev_r; // Last dedicated sample
   reg frame_done_r; // Frame finished on the previous edge

   // Scanning runs only with both the clock enable and the scan bit set
   wire active = keypad_clock_enable_r & keypad_ctrl_low_r[`CTRL_LOW_SCAN_BIT];
   wire [11:0] row_en = {row_enable_high_r[3:0], row_enable_low_r};
   wire [7:0] col_mask = column_enable_r & ~{4'h0, keypad_ctrl_high_r[3:0]};
   wire [3:0] confirm_need = keypad_ctrl_high_r[7:4];
   wire [6:0] deb_field = keypad_ctrl_low_r[7:1];
   wire [31:0] deb_limit = deb_field * DEBOUNCE_STEP;

   // A row's pressed columns are low; special key shows on the pass with no row driven low
   wire [7:0] pressed_now = ~col_sync_r & col_mask;

   // ****************************************************************
   // Pin control
   // ****************************************************************
   // Enabled column pins get pull-ups from this block, no GPIO setup needed
   assign column_pullup = column_enable_r;

   // Registers are plain flops, so every access completes in its first cycle
   // Zero wait APB, no error responses
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ****************************************************************
   // Synchroniser
   // ****************************************************************
   // Columns idle high through their pull-ups, so reset to ones: no false key
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         col_meta_r <= {COLS{1'b1}};
         col_sync_r <= {COLS{1'b1}};
      end
      else
      begin
         col_meta_r <= column_in;
         col_sync_r <= col_meta_r;
      end
   end

   // ****************************************************************
   // Row scan: row index 12 is a pass with no row driven low, for special keys
   // ****************************************************************
   // Rows lag the index by one edge and the columns by two more, so the
   // dwell must span at least four clocks or the previous row is read
   wire frame_end = active && (dwell_r == DWELL_CYCLES - 1) && (row_idx_r == 4'd12);

   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         row_idx_r <= 4'h0;
         dwell_r <= 16'h0;
         frame_r <= 96'h0;
         special_acc_r <= 8'h0;
         row_out <= {ROWS{1'b1}};
         row_oe <= {ROWS{1'b0}};
      end
      else if (!active)
      begin
         // Stopped: rows released and scan restarts from row 0
         row_idx_r <= 4'h0;
         // Rows return high too, so no row is left low with its enable off
         row_out <= {ROWS{1'b1}};
         dwell_r <= 16'h0;
         row_oe <= {ROWS{1'b0}};
      end
      else
      begin
         // Drive only enabled rows, low while selected
         row_out <= {ROWS{1'b1}};
         row_oe <= row_en;
         if (row_idx_r < 4'd12 && row_en[row_idx_r])
            row_out[row_idx_r] <= 1'b0;
         if (dwell_r == DWELL_CYCLES - 1)
         begin
            dwell_r <= 16'h0;
            if (row_idx_r == 4'd12)
            begin
               // Pass with all rows high: a low column is a grounded special key
               special_acc_r <= pressed_now;
               row_idx_r <= 4'h0;
            end
            else
            begin
               if (row_en[row_idx_r])
                  frame_r[row_idx_r*8 +: 8] <= pressed_now;
               else
                  frame_r[row_idx_r*8 +: 8] <= 8'h0;
               row_idx_r <= row_idx_r + 4'h1;
            end
         end
         else
            dwell_r <= dwell_r + 16'h1;
      end
   end

   // Frame completion one edge late, once the special pass is captured
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         frame_done_r <= 1'b0;
      else
         frame_done_r <= frame_end;
   end

   // ****************************************************************
   // Key selection: first three keys of a map, skipping special lines
   // ****************************************************************
   reg [7:0] pick0, pick1, pick2;
   reg [1:0] found;
   integer r, c;
   // Row-major walk, so a lower row always takes the earlier record
   always @*
   begin
      pick0 = `KEY_RECORD_RESET;
      pick1 = `KEY_RECORD_RESET;
      pick2 = `KEY_RECORD_RESET;
      found = 2'd0;
      for (r = 0; r < 12; r = r + 1)
         for (c = 0; c < 8; c = c + 1)
            // Keys on a line whose special key is down are ignored
            if (stable_r[r*8+c] && !special_stable_r[c])
            begin
               // Record layout: release bit 7, row 6..3, column 2..0
               if (found == 2'd0)
                  pick0 = {1'b0, r[3:0], c[2:0]};
               else if (found == 2'd1)
                  pick1 = {1'b0, r[3:0], c[2:0]};
               else if (found == 2'd2)
                  pick2 = {1'b0, r[3:0], c[2:0]};
               if (found != 2'd3)
                  found = found + 2'd1;
            end
   end

   // ****************************************************************
   // Debounce and confirmation, then report update
   // ****************************************************************
   // Debounce restarts on each change, so a chattering key never confirms
   // Report events of this cycle; a read clear never hides one
   wire [3:0] ded_now = col_sync_r[3:0] | ~keypad_ctrl_high_r[3:0];
   wire rec_change = (pick0 != rec_r[0]) || (pick1 != rec_r[1]) || (pick2 != rec_r[2]) ||
      (~special_stable_r != special_key_status_r);
   wire ded_change = keypad_clock_enable_r && (ded_now != ded_prev_r);
   wire key_read = psel && penable && !pwrite && (paddr >= `OFS_KEY_RECORD_0) &&
      (paddr <= `OFS_DEDICATED_STATUS);
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         deb_cnt_r <= 32'h0;
         confirm_r <= 4'h0;
         cand_r <= 96'h0;
         special_cand_r <= 8'h0;
         special_stable_r <= 8'h0;
         stable_r <= 96'h0;
         rec_r[0] <= `KEY_RECORD_RESET;
         rec_r[1] <= `KEY_RECORD_RESET;
         rec_r[2] <= `KEY_RECORD_RESET;
         special_key_status_r <= `SPECIAL_STATUS_RESET;
         dedicated_key_status_r <= 4'hf;
         ded_prev_r <= 4'hf;
         unread_r <= 1'b0;
      end
      else
      begin
         if (deb_cnt_r < deb_limit)
            deb_cnt_r <= deb_cnt_r + 32'h1;
         // Compare one edge after the frame, so the special pass is included
         if (frame_done_r)
         begin
            if (frame_r != cand_r || special_acc_r != special_cand_r)
            begin
               // Map changed: restart confirmation and debounce
               cand_r <= frame_r;
               special_cand_r <= special_acc_r;
               confirm_r <= 4'h0;
               deb_cnt_r <= 32'h0;
            end
            else if (confirm_r < confirm_need)
               confirm_r <= confirm_r + 4'h1;
         end
         // Confirmed map enters the report; special keys confirm with it
         if (confirm_r == confirm_need && deb_cnt_r >= deb_limit &&
             (stable_r != cand_r || special_stable_r != special_cand_r))
         begin
            stable_r <= cand_r;
            special_stable_r <= special_cand_r;
         end
         // Records track selection; masked keys turn no-key, return as presses
         if (rec_change)
         begin
            rec_r[0] <= pick0;
            rec_r[1] <= pick1;
            rec_r[2] <= pick2;
            special_key_status_r <= ~special_stable_r;
         end
         // Dedicated keys bypass the matrix, sampled only while the clock enable is set
         ded_prev_r <= ded_now;
         if (keypad_clock_enable_r)
            dedicated_key_status_r <= ded_now;
         // Unread state: a new event wins over a read in the same cycle
         if (rec_change || ded_change)
            unread_r <= 1'b1;
         else if (key_read)
            unread_r <= 1'b0;
      end
   end

   // Interrupt level follows unread state
   // Registered, so the pin stays clean while records are updated
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         key_irq <= 1'b0;
      else
         key_irq <= unread_r;
   end

   // ****************************************************************
   // APB writes
   // ****************************************************************
   // Unmapped writes are dropped with no error response
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         column_enable_r <= 8'h0;
         keypad_ctrl_high_r <= 8'h0;
         keypad_ctrl_low_r <= 8'h0;
         row_enable_low_r <= 8'h0;
         row_enable_high_r <= 8'h0;
         keypad_clock_enable_r <= 1'b0;
      end
      else if (psel && penable && pwrite)
      begin
         case (paddr)
            `OFS_COLUMN_ENABLE: column_enable_r <= pwdata[7:0];
            `OFS_CTRL_HIGH: keypad_ctrl_high_r <= pwdata[7:0];
            `OFS_CTRL_LOW: keypad_ctrl_low_r <= pwdata[7:0];
            `OFS_ROW_ENABLE_LOW: row_enable_low_r <= pwdata[7:0];
            `OFS_ROW_ENABLE_HIGH: row_enable_high_r <= {4'h0, pwdata[3:0]};
            `OFS_SYS_CTRL: keypad_clock_enable_r <= pwdata[0];
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // APB reads, registered on the setup cycle
   // ****************************************************************
   // Taken at the setup edge, so the data stands through the access phase
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         prdata <= 32'h0;
      else if (psel && !penable)
      begin
         case (paddr)
            `OFS_COLUMN_ENABLE: prdata <= {24'h0, column_enable_r};
            `OFS_CTRL_HIGH: prdata <= {24'h0, keypad_ctrl_high_r};
            `OFS_CTRL_LOW: prdata <= {24'h0, keypad_ctrl_low_r};
            `OFS_ROW_ENABLE_LOW: prdata <= {24'h0, row_enable_low_r};
            `OFS_ROW_ENABLE_HIGH: prdata <= {24'h0, row_enable_high_r};
            `OFS_SYS_CTRL: prdata <= {31'h0, keypad_clock_enable_r};
            `OFS_KEY_RECORD_0: prdata <= {24'h0, rec_r[0]};
            `OFS_KEY_RECORD_1: prdata <= {24'h0, rec_r[1]};
            `OFS_KEY_RECORD_2: prdata <= {24'h0, rec_r[2]};
            `OFS_SPECIAL_STATUS: prdata <= {24'h0, special_key_status_r};
            `OFS_DEDICATED_STATUS: prdata <= {28'h0, dedicated_key_status_r};
            default: prdata <= 32'h0;
         endcase
      end
   end

endmodule

`default_nettype wire

// [keypad_properties.sv]
/*
 Checker of the keypad scanner ports.
 Assumes it is bound to every keypad_scan_report instance.
*/
`timescale 1ns/100ps
`default_nettype none
module keypad_properties #(parameter ROWS = 12, parameter COLS = 8)
(
   // Clock and reset
   input wire clock,
   input wire rst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Keypad pins
   input wire [ROWS-1:0] row_out,
   input wire [ROWS-1:0] row_oe,
   input wire [COLS-1:0] column_in,
   input wire [COLS-1:0] column_pullup,
   input wire key_irq
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Read access phase, and one aimed at the key data bytes
   wire rd = psel && penable && !pwrite;
   wire rec = rd && paddr >= 12'h018 && paddr <= 12'h028;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_bus_no_wait: assert property (pready && !pslverr) else $error("bus answer wrong");
   // Interrupt may only drop two edges after a key data read
   a_irq_fall_read: assert property ($fell(key_irq) |-> $past(rec, 2))
      else $error("interrupt dropped without read");
   // At most one row low, and only a driven one
   a_row_single: assert property ($onehot0(~row_out) && !(~row_out & ~row_oe))
      else $error("row drive wrong");
   a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (rd && paddr > 12'h028 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_dedic_upper: assert property (rd && paddr == 12'h028 |-> prdata[7:4] == 4'h0)
      else $error("dedicated upper bits set");
   a_record_row: assert property (rec && paddr != 12'h028 && paddr != 12'h024 |->
      prdata[6:3] <= 4'hb || prdata[6:3] == 4'hf)
      else $error("record row out of range");
   a_nokey_rel: assert property (rec && paddr <= 12'h020 && prdata[6:3] == 4'hf |->
      prdata[7:0] == 8'hf8)
      else $error("no-key record not released");
   // Read data must stand through the access phase
   a_rdata_stands: assert property (psel && !penable |=> ##1 $stable(prdata))
      else $error("read data moved");
   c_irq_rise: cover property ($rose(key_irq));
   c_irq_fall: cover property ($fell(key_irq));
   c_key_seen: cover property (rec && prdata[6:3] != 4'hf);
endmodule
bind keypad_scan_report keypad_properties #(.ROWS(ROWS), .COLS(COLS)) props (
   .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .row_out(row_out), .row_oe(row_oe), .column_in(column_in),
   .column_pullup(column_pullup), .key_irq(key_irq));
`default_nettype wire

// [keypad_matrix.sv]
/*
 Switch matrix with special and dedicated keys.
 Assumes rows are active low and key state comes from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module keypad_matrix (
   // Clock
   input wire logic clock,
   // Device pins
   input wire logic [11:0] row_out,
   input wire logic [11:0] row_oe,
   input wire logic [7:0] column_pullup,
   output logic [7:0] column_in,
   // Key state, index row*8+column
   input wire logic [95:0] pressed,
   input wire logic [7:0] special,
   input wire logic [3:0] dedicated
);
   // ****************************************************************
   // Contact logic
   // ****************************************************************
   // Pattern for a floating line, so no settled value fools the design
   logic [7:0] flick = 8'h55;
   always @(posedge clock) flick <= ~flick;
   // Each closed contact pulls its column to the driven row level
   always @*
   begin
      column_in = 8'hff;
      for (int r = 0; r < 12; r++)
         for (int c = 0; c < 8; c++)
            if (pressed[r*8+c] && row_oe[r] && !row_out[r])
               column_in[c] = 1'b0;
      column_in = column_in & ~special & ~{4'h0, dedicated};
      // Line without its pull-up floats
      column_in = (column_in & column_pullup) | (flick & ~column_pullup);
   end
endmodule
`default_nettype wire

// [keypad_scan_report_bench.sv]
/*
 Self-checking bench of the keypad scanner.
 Assumes the matrix model on the pins and short dwell counts.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module keypad_scan_report_bench;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [95:0] pressed = 96'h0;
   logic [7:0] special = 8'h00;
   logic [3:0] dedicated = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, key_irq;
   wire [11:0] row_out, row_oe;
   wire [7:0] column_in, column_pullup;
   int fails = 0;
   int tests_run = 0;
   initial forever #2.5 clock = ~clock;
   keypad_scan_report #(.DWELL_CYCLES(4), .DEBOUNCE_STEP(8)) uut (.clock(clock), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .row_out(row_out),
      .row_oe(row_oe), .column_in(column_in), .column_pullup(column_pullup),
      .key_irq(key_irq));
   keypad_matrix pad (.clock(clock), .row_out(row_out), .row_oe(row_oe),
      .column_pullup(column_pullup), .column_in(column_in), .pressed(pressed),
      .special(special), .dedicated(dedicated));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task report_and_stop;
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20)
      begin
         fails++;
         report_and_stop();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   // Reads again until the expected value appears, since scans take many frames
   task poll(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      for (int i = 0; i < 200 && q !== e; i++)
         apb(1'b0, a, 32'h0, q);
      `CHECK(q, e)
   endtask
   task wait_irq;
      for (int i = 0; i < 3000 && key_irq !== 1'b1; i++)
         @(posedge clock);
      `CHECK(key_irq, 1'b1)
   endtask
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial
   begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      poll(12'h018, 32'hf8);
      poll(12'h01c, 32'hf8);
      poll(12'h024, 32'hff);
      poll(12'h028, 32'h0f);
      poll(12'h02c, 32'h0);
      `CHECK(row_oe, 12'h000)
      // Counts first, then clock, then scan; column 7 and row 11 stay off
      wr(12'h000, 32'h7f);
      wr(12'h004, 32'h11);
      wr(12'h00c, 32'hff);
      wr(12'h010, 32'h07);
      wr(12'h008, 32'h02);
      wr(12'h014, 32'h01);
      wr(12'h008, 32'h03);
      `CHECK(column_pullup, 8'h7f)
      repeat (4) @(posedge clock);
      `CHECK(row_oe, 12'h7ff)
      pressed <= (96'h1 << 46) | (96'h1 << 39) | (96'h1 << 90);
      wait_irq();
      poll(12'h018, 32'h2e);
      poll(12'h020, 32'hf8);
      pressed[19] <= 1'b1;
      poll(12'h018, 32'h13);
      poll(12'h01c, 32'h2e);
      dedicated[0] <= 1'b1;
      poll(12'h028, 32'h0e);
      special[6] <= 1'b1;
      poll(12'h024, 32'hbf);
      poll(12'h01c, 32'hf8);
      special[6] <= 1'b0;
      poll(12'h01c, 32'h2e);
      special[6] <= 1'b1;
      poll(12'h01c, 32'hf8);
      pressed[46] <= 1'b0;
      repeat (400) @(posedge clock);
      `CHECK(key_irq, 1'b0)
      poll(12'h01c, 32'hf8);
      special[6] <= 1'b0;
      pressed[46] <= 1'b1;
      pressed[73] <= 1'b1;
      poll(12'h020, 32'h49);
      poll(12'h01c, 32'h2e);
      poll(12'h024, 32'hff);
      poll(12'h018, 32'h13);
      repeat (3) @(posedge clock);
      `CHECK(key_irq, 1'b0)
      wr(12'h014, 32'h00);
      repeat (4) @(posedge clock);
      `CHECK(row_oe, 12'h000)
      wr(12'h014, 32'h01);
      repeat (4) @(posedge clock);
      `CHECK(row_oe, 12'h7ff)
      wr(12'h008, 32'h02);
      repeat (4) @(posedge clock);
      `CHECK(row_oe, 12'h000)
      report_and_stop();
   end
endmodule
`default_nettype wire
